//--- rtl/sfspi_pkg.sv
// Shared types, constants and lane helpers for the serial flash link
package sfspi_pkg;

    typedef enum logic [1:0] {
        SFSPI_SINGLE,
        SFSPI_DUAL,
        SFSPI_QUAD
    } sfspi_lane_t;

    localparam int SFSPI_BYTE_W      = 8;
    localparam int SFSPI_WORD_W      = SFSPI_BYTE_W + 2;
    localparam int SFSPI_CLK_MHZ     = 125;
    localparam int SFSPI_SCLK_MAX_MHZ = 133;
    // Least half period of the link clock, rounded up to whole clk cycles
    localparam int SFSPI_HALF_MIN    = (SFSPI_CLK_MHZ + 2 * SFSPI_SCLK_MAX_MHZ - 1) / (2 * SFSPI_SCLK_MAX_MHZ);
    // Host reads through a two-flop synchroniser, so a half period needs three cycles
    localparam int SFSPI_HALF_SYNC   = 3;
    localparam int SFSPI_HALF_DEF    = (SFSPI_HALF_MIN > SFSPI_HALF_SYNC) ? SFSPI_HALF_MIN : SFSPI_HALF_SYNC;
    localparam int SFSPI_CS_GAP_DEF  = 4;
    localparam logic       SFSPI_CS_IDLE = 1'b1;
    localparam logic [2:0] SFSPI_CNT_RST = 3'h0;

    function automatic logic [2:0] sfspi_last_step(sfspi_lane_t m);
        case (m)
            SFSPI_DUAL: sfspi_last_step = 3'h3;
            SFSPI_QUAD: sfspi_last_step = 3'h1;
            default:    sfspi_last_step = 3'h7;
        endcase
    endfunction

    // so: a single-lane bit travels on lane 1 (flash output) instead of lane 0
    function automatic logic [7:0] sfspi_shift_in(logic [7:0] sr, logic [3:0] io, sfspi_lane_t m, logic so);
        case (m)
            SFSPI_DUAL: sfspi_shift_in = {sr[5:0], io[1:0]};
            SFSPI_QUAD: sfspi_shift_in = {sr[3:0], io[3:0]};
            default:    sfspi_shift_in = {sr[6:0], so ? io[1] : io[0]};
        endcase
    endfunction

    function automatic logic [7:0] sfspi_shift_out(logic [7:0] sr, sfspi_lane_t m);
        case (m)
            SFSPI_DUAL: sfspi_shift_out = {sr[5:0], 2'h0};
            SFSPI_QUAD: sfspi_shift_out = {sr[3:0], 4'h0};
            default:    sfspi_shift_out = {sr[6:0], 1'b0};
        endcase
    endfunction

    function automatic logic [3:0] sfspi_lane_bits(logic [7:0] sr, sfspi_lane_t m, logic so);
        case (m)
            SFSPI_DUAL: sfspi_lane_bits = {2'h0, sr[7:6]};
            SFSPI_QUAD: sfspi_lane_bits = sr[7:4];
            default:    sfspi_lane_bits = so ? {2'h0, sr[7], 1'b0} : {3'h0, sr[7]};
        endcase
    endfunction

    function automatic logic [3:0] sfspi_lane_oe(sfspi_lane_t m, logic so);
        case (m)
            SFSPI_DUAL: sfspi_lane_oe = 4'h3;
            SFSPI_QUAD: sfspi_lane_oe = 4'hF;
            default:    sfspi_lane_oe = so ? 4'h2 : 4'h1;
        endcase
    endfunction

endpackage

//--- rtl/sfspi_if.sv
// Serial link between the controller end and the flash end
`timescale 1ns/1ps
interface sfspi_if;
    logic       cs_n;     // Chip select, low selects
    logic       sclk;     // Link clock from the controller
    logic [3:0] host_out; // Controller lane drive values
    logic [3:0] host_oe;  // Controller lane enables
    logic [3:0] dev_out;  // Flash lane drive values
    logic [3:0] dev_oe;   // Flash lane enables
    logic [3:0] io;       // Resolved lane levels

    // Undriven lanes read as pulled up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io[i] = dev_oe[i] ? dev_out[i] : (host_oe[i] ? host_out[i] : 1'b1);
        end
    end

    modport host (output cs_n, output sclk, output host_out, output host_oe, input io);
    modport dev  (input cs_n, input sclk, output dev_out, output dev_oe, input io);
endinterface

//--- rtl/sfspi_dev.sv
// Flash-side end: frame logic on the link clock, user stream logic on clk
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Functional notes
// (RL1) Chip select high releases every data lane
// (RL2) No instruction accepted before first select fall
// (RL3) Selected: shift instructions in, data out
// (RL4) Single lane input sampled on rising clock
// (RL5) Single lane output changes on falling clock
// (RL6) Wide lanes: in on rising, out falling
// (RL7) Single/dual use lanes 0-1, quad 0-3
// (RL8) Clock modes 0 and 3 both work
// (RL9) Master holds clock idle at select edges
// (RL10) Link clock at most 133 MHz
// (RL11) Select rise ends frame, restarts bit count
module sfspi_dev (
    input  logic                          clk,      // System clock
    input  logic                          rst_n,    // Synchronous reset, low active
    input  logic                          clk_en,   // Freezes user-side state when low
    sfspi_if.dev                          link,     // Serial link
    input  sfspi_pkg::sfspi_lane_t        rx_mode,  // Lane mode of bytes after the first
    output logic                          rx_valid, // Received byte pulse
    output logic [sfspi_pkg::SFSPI_BYTE_W-1:0] rx_data,  // Received byte
    output logic                          rx_first, // Byte was the frame's first
    input  logic                          tx_valid, // Byte to send offered
    output logic                          tx_ready, // Buffer can take a byte
    input  logic [sfspi_pkg::SFSPI_BYTE_W-1:0] tx_data,  // Byte to send
    input  sfspi_pkg::sfspi_lane_t        tx_mode,  // Lane mode for that byte
    output logic                          selected  // Selected and armed
);
    import sfspi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State types

    typedef struct packed {
        logic                                 rst_q;
        logic                                 cs_s1;
        logic                                 cs_s2;
        logic                                 armed;
        logic                                 rxt_s1;
        logic                                 rxt_s2;
        logic                                 rxt_seen;
        logic                                 ack_s1;
        logic                                 ack_s2;
        logic                                 xreq;
        logic                                 xbusy;
        logic [SFSPI_WORD_W-1:0]              xword;
        logic [1:0][SFSPI_WORD_W-1:0]         mem;
        logic                                 wp;
        logic                                 rp;
        logic [1:0]                           cnt;
        logic                                 rxv;
        logic [SFSPI_BYTE_W-1:0]              rxd;
        logic                                 rxf;
    } sfspi_dclk_t;

    typedef struct packed {
        logic [2:0]              cnt;
        logic [SFSPI_BYTE_W-1:0] sr;
        logic                    instr;
        sfspi_lane_t             ms1;
        sfspi_lane_t             ms2;
    } sfspi_dpos_t;

    typedef struct packed {
        logic [SFSPI_BYTE_W-1:0] hold;
        logic                    first;
        logic                    tgl;
    } sfspi_dhand_t;

    typedef struct packed {
        logic [SFSPI_BYTE_W-1:0] sr;
        sfspi_lane_t             mode;
        logic [2:0]              cnt;
        logic                    drive;
    } sfspi_dneg_t;

    typedef struct packed {
        logic                    rs1;
        logic                    rs2;
        logic                    ack;
        logic                    nv;
        logic [SFSPI_WORD_W-1:0] nword;
    } sfspi_dack_t;

    localparam sfspi_dclk_t C_RST = '{rst_q: 1'b1, cs_s1: SFSPI_CS_IDLE, cs_s2: SFSPI_CS_IDLE, default: '0};

    sfspi_dclk_t  c_reg, c_next;
    sfspi_dpos_t  p_reg, p_next;
    sfspi_dhand_t h_reg, h_next;
    sfspi_dneg_t  n_reg, n_next;
    sfspi_dack_t  q_reg, q_next;
    logic         link_rst;
    logic         frame_rst;
    logic         byte_done;
    logic         tx_load;
    logic         tx_take;
    logic         push;
    logic         pop;
    sfspi_lane_t  p_mode;

    ////////////////////////////////////////////////////////////////////////////
    // User side on clk

    always_comb begin
        c_next = c_reg;
        push   = 1'b0;
        pop    = 1'b0;
        if (clk_en) begin
            c_next.rst_q  = 1'b0;
            c_next.cs_s1  = link.cs_n;
            c_next.cs_s2  = c_reg.cs_s1;
            c_next.rxt_s1 = h_reg.tgl;
            c_next.rxt_s2 = c_reg.rxt_s1;
            c_next.ack_s1 = q_reg.ack;
            c_next.ack_s2 = c_reg.ack_s1;
            c_next.rxv    = 1'b0;
            // Synchroniser resets to the deselect level, so the device arms on the first enabled cycle after reset
            if (c_reg.cs_s2) begin
                c_next.armed = 1'b1; // RL2
            end
            if (c_reg.rxt_s2 != c_reg.rxt_seen) begin
                c_next.rxt_seen = c_reg.rxt_s2;
                // Bytes of a frame begun before arming are dropped
                if (c_reg.armed) begin // RL2
                    c_next.rxv = 1'b1;
                    c_next.rxd = h_reg.hold;
                    c_next.rxf = h_reg.first;
                end
            end
            if (c_reg.xbusy && c_reg.ack_s2 == c_reg.xreq) begin
                c_next.xbusy = 1'b0;
            end
            pop  = !c_reg.xbusy && c_reg.cnt != 2'h0;
            push = tx_valid && c_reg.armed && c_reg.cnt != 2'h2;
            if (pop) begin
                c_next.xword = c_reg.mem[c_reg.rp];
                c_next.xreq  = ~c_reg.xreq;
                c_next.xbusy = 1'b1;
                c_next.rp    = ~c_reg.rp;
            end
            if (push) begin
                c_next.mem[c_reg.wp] = {tx_mode, tx_data};
                c_next.wp            = ~c_reg.wp;
            end
            c_next.cnt = c_reg.cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c_reg <= C_RST;
        end else begin
            c_reg <= c_next;
        end
    end

    assign tx_ready = clk_en && c_reg.armed && c_reg.cnt != 2'h2;
    assign rx_valid = c_reg.rxv;
    assign rx_data  = c_reg.rxd;
    assign rx_first = c_reg.rxf;
    assign selected = c_reg.armed && !c_reg.cs_s2;

    ////////////////////////////////////////////////////////////////////////////
    // Link side, rising edges: input shifting

    // Link clock stands still outside frames, so select itself clears the frame
    assign link_rst  = c_reg.rst_q;
    assign frame_rst = link.cs_n | c_reg.rst_q; // RL11

    always_comb begin
        // First byte of a frame is always the single-lane instruction
        p_mode      = p_reg.instr ? p_reg.ms2 : SFSPI_SINGLE; // RL7
        p_next      = p_reg;
        p_next.ms1  = rx_mode;
        p_next.ms2  = p_reg.ms1;
        p_next.sr   = sfspi_shift_in(p_reg.sr, link.io, p_mode, 1'b0); // RL4 RL6
        byte_done   = p_reg.cnt == sfspi_last_step(p_mode);
        p_next.cnt  = byte_done ? SFSPI_CNT_RST : p_reg.cnt + 3'h1;
        if (byte_done) begin
            p_next.instr = 1'b1; // RL3
        end
        h_next = h_reg;
        // Lanes the flash drives itself carry no input
        if (byte_done && !n_reg.drive) begin
            h_next.hold  = p_next.sr;
            h_next.first = !p_reg.instr;
            h_next.tgl   = ~h_reg.tgl;
        end
    end

    // Rising edge sampling serves modes 0 and 3 alike
    always_ff @(posedge link.sclk or posedge frame_rst) begin // RL8
        if (frame_rst) begin
            p_reg <= '0;
        end else begin
            p_reg <= p_next;
        end
    end

    always_ff @(posedge link.sclk or posedge link_rst) begin
        if (link_rst) begin
            h_reg <= '0;
        end else begin
            h_reg <= h_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link side, falling edges: output shifting

    // Output starts only on a byte boundary after the instruction
    assign tx_load = q_reg.nv
                     && (n_reg.drive ? n_reg.cnt == sfspi_last_step(n_reg.mode)
                                     : (p_reg.instr && p_reg.cnt == SFSPI_CNT_RST));
    // Word parked one byte ahead: the crossing is too slow for quad bytes back to back
    assign tx_take = (q_reg.rs2 != q_reg.ack) && (!q_reg.nv || tx_load);

    always_comb begin
        q_next     = q_reg;
        q_next.rs1 = c_reg.xreq;
        q_next.rs2 = q_reg.rs1;
        q_next.ack = q_reg.ack ^ tx_take;
        if (tx_take) begin
            q_next.nv    = 1'b1;
            q_next.nword = c_reg.xword;
        end else if (tx_load) begin
            q_next.nv = 1'b0;
        end
        n_next     = n_reg;
        if (tx_load) begin
            n_next.sr    = q_reg.nword[SFSPI_BYTE_W-1:0];
            n_next.mode  = sfspi_lane_t'(q_reg.nword[SFSPI_WORD_W-1:SFSPI_BYTE_W]);
            n_next.cnt   = SFSPI_CNT_RST;
            n_next.drive = 1'b1; // RL3
        end else if (n_reg.drive) begin
            if (n_reg.cnt == sfspi_last_step(n_reg.mode)) begin
                n_next.drive = 1'b0;
            end else begin
                n_next.sr  = sfspi_shift_out(n_reg.sr, n_reg.mode); // RL5 RL6
                n_next.cnt = n_reg.cnt + 3'h1;
            end
        end
    end

    always_ff @(negedge link.sclk or posedge frame_rst) begin
        if (frame_rst) begin
            n_reg <= '0;
        end else begin
            n_reg <= n_next;
        end
    end

    always_ff @(negedge link.sclk or posedge link_rst) begin
        if (link_rst) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign link.dev_out = sfspi_lane_bits(n_reg.sr, n_reg.mode, 1'b1); // RL7
    assign link.dev_oe  = (n_reg.drive && !link.cs_n) ? sfspi_lane_oe(n_reg.mode, 1'b1) : 4'h0; // RL1

endmodule

//--- rtl/sfspi_host.sv
// Controller end: makes the link clock and chip select, shifts command bytes
`timescale 1ns/1ps
module sfspi_host #(
    parameter int HALF   = sfspi_pkg::SFSPI_HALF_DEF,   // clk cycles per link clock half
    parameter int CS_GAP = sfspi_pkg::SFSPI_CS_GAP_DEF  // clk cycles of deselect between frames
) (
    input  logic                          clk,       // System clock
    input  logic                          rst_n,     // Synchronous reset, low active
    input  logic                          clk_en,    // Freezes all state when low
    sfspi_if.host                         link,      // Serial link
    input  logic                          mode3,     // Link clock idles high
    input  logic                          cmd_valid, // Byte command offered
    output logic                          cmd_ready, // Command taken
    input  logic [sfspi_pkg::SFSPI_BYTE_W-1:0] cmd_data,  // Byte to write
    input  sfspi_pkg::sfspi_lane_t        cmd_lane,  // Lane mode of this byte
    input  logic                          cmd_read,  // Read a byte instead
    input  logic                          cmd_last,  // Deselect after this byte
    output logic                          rd_valid,  // Read byte held
    input  logic                          rd_ready,  // Read byte consumed
    output logic [sfspi_pkg::SFSPI_BYTE_W-1:0] rd_data,   // Read byte
    output logic                          busy       // Frame in progress
);
    import sfspi_pkg::*;

    typedef enum {H_GAP, H_IDLE, H_START, H_LOW, H_HIGH, H_WAIT, H_END} sfspi_hst_t;

    typedef struct packed {
        sfspi_hst_t              st;
        logic                    cs_n;
        logic                    sclk;
        logic                    cpol;
        logic [7:0]              tim;
        logic [2:0]              cnt;
        logic [SFSPI_BYTE_W-1:0] sr;
        sfspi_lane_t             lane;
        logic                    rd;
        logic                    last;
        logic [3:0]              oe;
        logic [3:0]              s1;
        logic [3:0]              s2;
        logic                    rdv;
        logic [SFSPI_BYTE_W-1:0] rdd;
    } sfspi_host_t;

    localparam logic [7:0] HALF_END = 8'(HALF - 1);
    localparam logic [7:0] GAP_END  = 8'(CS_GAP - 1);

    sfspi_host_t r_reg, r_next;
    logic        take;
    logic        tim_end;

    ////////////////////////////////////////////////////////////////////////////

    // A read waits while the last read byte is still unclaimed
    assign cmd_ready = clk_en && (r_reg.st == H_IDLE || r_reg.st == H_WAIT) && !(cmd_read && r_reg.rdv);
    assign take      = cmd_valid && cmd_ready;
    assign tim_end   = r_reg.tim == HALF_END; // RL10

    always_comb begin
        r_next = r_reg;
        if (clk_en) begin
            r_next.s1  = link.io;
            r_next.s2  = r_reg.s1;
            r_next.tim = r_reg.tim + 8'h1;
            if (r_reg.rdv && rd_ready) begin
                r_next.rdv = 1'b0;
            end
            if (take) begin
                r_next.sr   = cmd_data;
                r_next.lane = cmd_lane;
                r_next.rd   = cmd_read;
                r_next.last = cmd_last;
                r_next.cnt  = SFSPI_CNT_RST;
                r_next.tim  = 8'h0;
            end
            case (r_reg.st)
                H_GAP: begin
                    r_next.cs_n = 1'b1;
                    if (r_reg.tim == GAP_END) begin
                        r_next.st = H_IDLE;
                    end
                end
                H_IDLE: begin
                    r_next.cpol = mode3;
                    r_next.sclk = mode3;
                    if (take) begin
                        r_next.cs_n = 1'b0; // RL2
                        r_next.st   = H_START;
                    end
                end
                H_START: begin
                    // Clock still at idle level while select falls
                    if (tim_end) begin // RL9
                        r_next.st   = H_LOW;
                        r_next.sclk = 1'b0;
                        r_next.tim  = 8'h0;
                        r_next.oe   = r_reg.rd ? 4'h0 : sfspi_lane_oe(r_reg.lane, 1'b0);
                    end
                end
                H_LOW: begin
                    if (tim_end) begin
                        r_next.st   = H_HIGH;
                        r_next.sclk = 1'b1;
                        r_next.tim  = 8'h0;
                        if (r_reg.rd) begin
                            r_next.sr = sfspi_shift_in(r_reg.sr, r_reg.s2, r_reg.lane, 1'b1);
                        end
                    end
                end
                H_HIGH: begin
                    if (tim_end) begin
                        r_next.tim = 8'h0;
                        if (r_reg.cnt == sfspi_last_step(r_reg.lane)) begin
                            if (r_reg.rd) begin
                                r_next.rdv = 1'b1;
                                r_next.rdd = r_reg.sr;
                            end
                            r_next.st = r_reg.last ? H_END : H_WAIT;
                            if (r_reg.last) begin
                                r_next.sclk = r_reg.cpol; // RL9
                                r_next.oe   = 4'h0;
                            end
                        end else begin
                            r_next.st   = H_LOW;
                            r_next.sclk = 1'b0;
                            r_next.cnt  = r_reg.cnt + 3'h1;
                            if (!r_reg.rd) begin
                                r_next.sr = sfspi_shift_out(r_reg.sr, r_reg.lane);
                            end
                        end
                    end
                end
                H_WAIT: begin
                    // Clock parked high between bytes of one frame
                    if (take) begin
                        r_next.st   = H_LOW;
                        r_next.sclk = 1'b0;
                        r_next.oe   = cmd_read ? 4'h0 : sfspi_lane_oe(cmd_lane, 1'b0); // RL7
                    end
                end
                H_END: begin
                    if (tim_end) begin
                        r_next.cs_n = 1'b1; // RL11
                        r_next.st   = H_GAP;
                        r_next.tim  = 8'h0;
                    end
                end
                default: begin
                    r_next.st = H_GAP;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg <= '{st: H_GAP, cs_n: SFSPI_CS_IDLE, lane: SFSPI_SINGLE, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.cs_n     = r_reg.cs_n;
    assign link.sclk     = r_reg.sclk;
    assign link.host_out = sfspi_lane_bits(r_reg.sr, r_reg.lane, 1'b0);
    assign link.host_oe  = r_reg.oe;
    assign rd_valid      = r_reg.rdv;
    assign rd_data       = r_reg.rdd;
    assign busy          = !r_reg.cs_n;

endmodule

//--- testbench/sfspi_sva.sv
// Link checker: lane ownership and clock edges
`timescale 1ns/1ps
module sfspi_sva (
    input logic       clk,      // System clock
    input logic       rst_n,    // Reset, low active
    input logic       cs_n,     // Chip select
    input logic       sclk,     // Link clock
    input logic [3:0] host_out, // Host lane values
    input logic [3:0] host_oe,  // Host lane enables
    input logic [3:0] dev_out,  // Flash lane values
    input logic [3:0] dev_oe    // Flash lane enables
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    AST_DEV_HIZ: assert property (cs_n |-> dev_oe == 4'h0)
        else $error("flash drives while deselected");
    AST_HOST_REL: assert property (cs_n |-> host_oe == 4'h0)
        else $error("host drives while deselected");
    AST_ONE_OWNER: assert property ((dev_oe & host_oe) == 4'h0)
        else $error("both ends drive a lane");
    AST_DEV_LANES: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("flash lane set illegal");
    AST_HOST_LANES: assert property (host_oe inside {4'h0, 4'h1, 4'h3, 4'hF})
        else $error("host lane set illegal");
    // Clock sits idle across both select edges
    AST_CS_EDGE: assert property ($changed(cs_n) |-> $stable(sclk) ##1 $stable(sclk))
        else $error("link clock moved at select edge");
    AST_DEV_FALL: assert property (dev_oe != 4'h0 && $changed(dev_out & dev_oe) |-> !sclk)
        else $error("flash data moved while clock high");
    AST_HOST_LOW: assert property (host_oe != 4'h0 && $changed(host_out & host_oe) |-> !sclk)
        else $error("host data moved while clock high");
    AST_HALF_MIN: assert property ($changed(sclk) |=> $stable(sclk) [*2])
        else $error("link clock half period too short");
endmodule

//--- testbench/testbench.sv
// Self-checking bench joining both ends of the serial flash link
`timescale 1ns/1ps
module testbench;
    import sfspi_pkg::*;
    logic        clk = 1'h0, rst_n = 1'h0, mode3 = 1'h0, cmd_valid = 1'h0, cmd_read = 1'h0;
    logic        cmd_last = 1'h0, rd_ready = 1'h0, tx_valid = 1'h0;
    logic [7:0]  cmd_data = 8'h00, tx_data = 8'h00;
    sfspi_lane_t cmd_lane = SFSPI_SINGLE, rx_mode = SFSPI_SINGLE, tx_mode = SFSPI_SINGLE;
    logic        cmd_ready, rd_valid, busy, rx_valid, rx_first, tx_ready, sel;
    logic [7:0]  rd_data, rx_data;
    logic [31:0] seed = 32'hd9df;
    int          errors = 0;
    int          compares = 0;
    logic [7:0]  exp_rx[$], exp_rd[$];
    logic        exp_first[$];
    sfspi_if link();
    sfspi_host u_sfspi_host (.clk(clk), .rst_n(rst_n), .clk_en(1'h1), .link(link), .mode3(mode3),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data), .cmd_lane(cmd_lane),
        .cmd_read(cmd_read), .cmd_last(cmd_last), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data), .busy(busy));
    sfspi_dev u_sfspi_dev (.clk(clk), .rst_n(rst_n), .clk_en(1'h1), .link(link), .rx_mode(rx_mode),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_mode(tx_mode), .selected(sel));
    sfspi_sva u_sfspi_sva (.clk(clk), .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
        .host_out(link.host_out), .host_oe(link.host_oe), .dev_out(link.dev_out), .dev_oe(link.dev_oe));
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Idle lane level with nobody driving
    function automatic logic [7:0] idle_io();
        return 8'h0F;
    endfunction
    task automatic cmp8(logic [7:0] got, logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(logic got, logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Valid stays up between bytes so it is never assigned twice per step
    task automatic send(logic [7:0] d, sfspi_lane_t l, logic rd, logic last);
        int n;
        n = 0;
        cmd_valid <= 1'h1;
        cmd_data <= d;
        cmd_lane <= l;
        cmd_read <= rd;
        cmd_last <= last;
        do begin
            @(posedge clk);
            n++;
        end while (cmd_ready !== 1'h1 && n < 3000);
        cmp1(n < 3000, 1'h1);
        @(negedge clk);
    endtask
    task automatic tx_push(logic [7:0] d, sfspi_lane_t l, output logic ok);
        int n;
        n = 0;
        tx_valid <= 1'h1;
        tx_data <= d;
        tx_mode <= l;
        do begin
            @(posedge clk);
            n++;
        end while (tx_ready !== 1'h1 && n < 40);
        ok = (tx_ready === 1'h1);
        @(negedge clk);
    endtask
    task automatic frame(logic [7:0] ins, sfspi_lane_t l, int nb, logic rd);
        logic [7:0] d;
        logic       ok;
        int         cnt, n;
        cnt = 0;
        rx_mode <= l;
        for (int i = 0; i < nb && rd; i++) begin
            d = 8'(rnd());
            tx_push(d, l, ok);
            if (ok) exp_rd.push_back(d);
            if (ok) cnt++;
        end
        tx_valid <= 1'h0;
        if (rd && nb == 4) cmp1(cnt >= 2 && cnt <= 3, 1'h1);
        if (!rd) cnt = nb;
        repeat (4) @(negedge clk);
        exp_rx.push_back(ins);
        exp_first.push_back(1'h1);
        send(ins, SFSPI_SINGLE, 1'h0, cnt == 0);
        for (int i = 0; i < cnt; i++) begin
            d = 8'(rnd());
            if (!rd) exp_rx.push_back(d);
            if (!rd) exp_first.push_back(1'h0);
            send(d, l, rd, i == cnt - 1);
        end
        cmd_valid <= 1'h0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((busy !== 1'h0 || rd_valid !== 1'h0) && n < 4000);
        cmp1(n < 4000, 1'h1);
        repeat (8) @(negedge clk);
        cmp8({4'h0, link.io}, idle_io());
        cmp1(link.sclk, mode3);
        cmp1(sel, 1'h0);
        cmp1(tx_ready, 1'h1);
        cmp8(8'(exp_rx.size() + exp_rd.size()), 8'h00);
        $display("frame %h lane %0d read %0d done", ins, l, rd);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) rd_ready <= (rnd() % 4) != 0;
    always @(posedge clk) begin
        if (rx_valid === 1'h1) begin
            cmp8(rx_data, exp_rx.pop_front());
            cmp1(rx_first, exp_first.pop_front());
            cmp1(sel, 1'h1);
        end
        if (rd_valid === 1'h1 && rd_ready === 1'h1) cmp8(rd_data, exp_rd.pop_front());
    end
    initial begin
        #(8 * 80000);
        errors++;
        final_report();
    end
    initial begin
        repeat (10) @(negedge clk);
        cmp1(sel, 1'h0);
        rst_n <= 1'h1;
        repeat (12) @(negedge clk);
        for (int m = 0; m < 2; m++) begin
            mode3 <= m[0];
            frame(8'h00, SFSPI_QUAD, 0, 1'h0);
            frame(8'hFF, SFSPI_QUAD, 4, 1'h1);
            for (int t = 0; t < 6; t++) frame(8'(rnd()), sfspi_lane_t'(t % 3), 1 + t / 3, t >= 3);
        end
        final_report();
    end
endmodule
